// >>> dv/host_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// Host side of the register port
// ----------------------------------------
module host_model (
  input wire logic core_clk,
  output logic [7:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [15:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // Released data is inverted so a stale bus never looks valid
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    #10;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge core_clk);
    #10;
    reg_wr = 1'b0;
    reg_wdata = ~d;
    reg_addr = ~a;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge core_clk);
    #10;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge core_clk);
    #10;
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask
endmodule

// >>> dv/testbench.sv
`timescale 1ns/1ps
`include "meter_map.svh"

module testbench;
  import meter_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;
  logic [15:0] status_first_flags = 16'h0000;
  logic [15:0] neutral_rms = 16'h0000;
  logic [15:0] neutral_thr = 16'hFFFF;
  logic neutral_second_over = 1'b0;
  logic [2:0][15:0] voltage_thd = '0;
  logic [2:0][15:0] current_thd = '0;
  logic [15:0] vthr = 16'h0064;
  logic [15:0] cthr = 16'h0064;
  logic energy_update = 1'b0;
  logic fine = 1'b0;
  logic [7:0] sign_fine = 8'h00;
  logic [7:0] sign_coarse = 8'h00;
  logic [5:0] wave_sign = 6'h00;
  logic irq_a;
  logic irq_b;
  logic [2:0] zx_out;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;
  int fb[5] = '{10, 7, 6, 3, 2};

  always #50 core_clk = ~core_clk;

  host_model host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  meter_status_irq uut (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .status_first_flags(status_first_flags),
    .neutral_rms(neutral_rms), .neutral_warning_threshold(neutral_thr),
    .neutral_second_over(neutral_second_over), .voltage_thd(voltage_thd), .current_thd(current_thd),
    .voltage_distortion_threshold(vthr), .current_distortion_threshold(cthr),
    .energy_update(energy_update), .energy_fine_resolution(fine), .energy_sign_fine(sign_fine),
    .energy_sign_coarse(sign_coarse), .wave_sign(wave_sign), .interrupt_pin_first(irq_a),
    .interrupt_pin_second(irq_b), .zx_out(zx_out));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic report_and_stop();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    host.rd(a, d);
    check(d, exp);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #10;
  endtask

  task automatic upd(input logic f, input logic [7:0] s);
    fine = f;
    if (f) sign_fine = s;
    else sign_coarse = s;
    energy_update = 1'b1;
    tick(1);
    energy_update = 1'b0;
    tick(1);
  endtask

  // Pulse must be one cycle wide, so the cycle after is checked too
  task automatic zx(input logic [15:0] cfg, input logic [5:0] m, input logic [2:0] up, input logic [2:0] dn);
    host.wr(`ADDR_ZX_SETUP, cfg);
    wave_sign = 6'h00;
    tick(2);
    wave_sign = m;
    tick(1);
    check({13'h0, zx_out}, {13'h0, up});
    tick(1);
    check({13'h0, zx_out}, 16'h0000);
    wave_sign = 6'h00;
    tick(1);
    check({13'h0, zx_out}, {13'h0, dn});
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 4000) begin
      n_fail++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic fx;
    repeat (12) @(posedge core_clk);
    #10;
    nrst = 1'b1;
    rchk(`ADDR_STATUS_SECOND, 16'h0000);
    rchk(`ADDR_EN_FIRST, 16'h0000);
    rchk(`ADDR_EN_SECOND, 16'h0000);
    rchk(`ADDR_ZX_SETUP, 16'h0001);
    host.wr(`ADDR_EN_FIRST, 16'hFFFF);
    rchk(`ADDR_EN_FIRST, 16'h04CC);
    host.wr(`ADDR_EN_SECOND, 16'hFFFF);
    rchk(`ADDR_EN_SECOND, 16'hCCFF);
    host.wr(8'h05, 16'hFFFF);
    rchk(8'h05, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      host.wr(`ADDR_EN_FIRST, 16'h1 << fb[i]);
      status_first_flags = 16'hFFFF ^ (16'h1 << fb[i]);
      tick(2);
      check({15'h0, irq_a}, 16'h0000);
      status_first_flags = 16'h1 << fb[i];
      tick(2);
      check({15'h0, irq_a}, 16'h0001);
    end
    status_first_flags = 16'h0000;
    host.wr(`ADDR_EN_SECOND, 16'h4000);
    rchk(`ADDR_STATUS_SECOND, 16'h0000);
    neutral_thr = 16'h7FFF;
    neutral_rms = 16'h7FFF;
    tick(2);
    rchk(`ADDR_STATUS_SECOND, 16'h0000);
    neutral_rms = 16'h8000;
    tick(2);
    check({15'h0, irq_b}, 16'h0001);
    neutral_rms = 16'h0000;
    rchk(`ADDR_STATUS_SECOND, 16'h4000);
    check({15'h0, irq_b}, 16'h0000);
    neutral_second_over = 1'b1;
    tick(1);
    neutral_second_over = 1'b0;
    tick(2);
    check({15'h0, irq_b}, 16'h0000);
    host.wr(`ADDR_EN_SECOND, 16'h8000);
    check({15'h0, irq_b}, 16'h0001);
    rchk(`ADDR_STATUS_SECOND, 16'h8000);
    voltage_thd[2] = 16'h0065;
    tick(2);
    check({15'h0, irq_b}, 16'h0000);
    host.wr(`ADDR_EN_SECOND, 16'h0800);
    check({15'h0, irq_b}, 16'h0001);
    voltage_thd[2] = 16'h0064;
    rchk(`ADDR_STATUS_SECOND, 16'h0800);
    current_thd[1] = 16'h0065;
    tick(2);
    current_thd[1] = 16'h0000;
    rchk(`ADDR_STATUS_SECOND, 16'h0400);
    host.wr(`ADDR_EN_SECOND, 16'h00FF);
    upd(1'b1, 8'h00);
    check({15'h0, irq_b}, 16'h0000);
    upd(1'b1, 8'hA5);
    check({15'h0, irq_b}, 16'h0001);
    rchk(`ADDR_STATUS_SECOND, 16'h00A5);
    upd(1'b0, 8'hFF);
    rchk(`ADDR_STATUS_SECOND, 16'h0000);
    upd(1'b0, 8'h0F);
    rchk(`ADDR_STATUS_SECOND, 16'h00F0);
    zx(16'h0005, 6'h01, 3'h0, 3'h0);
    zx(16'h0554, 6'h02, 3'h2, 3'h2);
    zx(16'h0068, 6'h01, 3'h1, 3'h2);
    for (int m = 0; m < 4; m++) begin
      zx((16'(m) << 1) | (16'(m) << 3) | (16'(m) << 5), 6'h01,
        {3{m == 0 || m == 2}}, {3{m == 1 || m == 2}});
    end
    for (int s = 0; s < 8; s++) begin
      fx = (s == 3 || s == 7);
      zx((16'(s) << 13) | (16'(s) << 10) | (16'(s) << 7) | 16'h0054,
        fx ? 6'h3F : 6'h01 << (s > 3 ? s - 1 : s),
        fx ? 3'h0 : 3'h7, fx ? 3'h0 : 3'h7);
    end
    report_and_stop();
  end
endmodule

// >>> include/meter_map.svh
`ifndef METER_MAP_SVH
`define METER_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_STATUS_FIRST 8'h01
`define ADDR_STATUS_SECOND 8'h02
`define ADDR_EN_FIRST 8'h03
`define ADDR_EN_SECOND 8'h04
`define ADDR_ZX_SETUP 8'h07

// ----------------------------------------
// Reset values and writable masks
// ----------------------------------------
`define RST_STATUS_SECOND 16'h0000
`define RST_EN_FIRST 16'h0000
`define RST_EN_SECOND 16'h0000
`define RST_ZX_SETUP 16'h0001
`define MASK_STATUS_SECOND 16'hCCFF
`define MASK_EN_FIRST 16'h04CC
`define MASK_EN_SECOND 16'hCCFF
`define MASK_ZX_SETUP 16'hFFFF

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_NEUTRAL_SECOND 15
`define BIT_NEUTRAL_COMPUTED 14
`define BIT_VOLTAGE_DIST 11
`define BIT_CURRENT_DIST 10
`define DIR_MSB 7
`define BIT_ZX_OFF 0
`define ZX_SRC_LSB0 7
`define ZX_MODE_LSB0 1
`define ZX_SRC_STEP 3
`define ZX_MODE_STEP 2

`endif

// >>> include/meter_pkg.sv
package meter_pkg;

  typedef enum logic [2:0] {
    SRC_VOLT_A = 3'h0,
    SRC_VOLT_B = 3'h1,
    SRC_VOLT_C = 3'h2,
    SRC_LOW_A = 3'h3,
    SRC_CURR_A = 3'h4,
    SRC_CURR_B = 3'h5,
    SRC_CURR_C = 3'h6,
    SRC_LOW_B = 3'h7
  } zx_source_t;

  typedef enum logic [1:0] {
    MODE_RISING = 2'h0,
    MODE_FALLING = 2'h1,
    MODE_BOTH = 2'h2,
    MODE_NONE = 2'h3
  } zx_mode_t;

  typedef struct packed {
    logic [15:0] status_second;
    logic [15:0] en_first;
    logic [15:0] en_second;
    logic [15:0] zx_setup;
    logic [7:0] dir_prev;
    logic dir_res_prev;
    logic dir_primed;
    logic [15:0] rdata;
    logic irq_first;
    logic irq_second;
  } ctl_state_t;

  typedef struct packed {
    logic [5:0] sign_prev;
    logic primed;
    logic out;
  } zx_state_t;

endpackage

// >>> logic/meter_status_irq.sv
`timescale 1ns/1ps
`include "meter_map.svh"


module meter_status_irq
  import meter_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [15:0] status_first_flags,
  input wire logic [15:0] neutral_rms,
  input wire logic [15:0] neutral_warning_threshold,
  input wire logic neutral_second_over,
  input wire logic [2:0][15:0] voltage_thd,
  input wire logic [2:0][15:0] current_thd,
  input wire logic [15:0] voltage_distortion_threshold,
  input wire logic [15:0] current_distortion_threshold,
  input wire logic energy_update,
  input wire logic energy_fine_resolution,
  input wire logic [7:0] energy_sign_fine,
  input wire logic [7:0] energy_sign_coarse,
  input wire logic [5:0] wave_sign,
  output logic interrupt_pin_first,
  output logic interrupt_pin_second,
  output logic [2:0] zx_out
);

  ctl_state_t st_reg;
  ctl_state_t st_next;

  logic [2:0] volt_over;
  logic [2:0] curr_over;
  logic neutral_computed_over;
  logic voltage_distortion_over;
  logic current_distortion_over;
  logic [7:0] dir_sel;
  logic dir_same_res;
  logic [7:0] dir_change;
  logic [15:0] status_set;
  logic [15:0] status_clr;
  logic rd_status;
  logic [15:0] rd_mux;
  logic [15:0] status_upd;
  logic [15:0] en_second_upd;
  logic [15:0] gated_second;
  logic gate_neutral;
  logic gate_dist;
  logic gate_dir;

  // ----------------------------------------
  // Threshold comparisons
  // ----------------------------------------
  // Unsigned compare; a threshold of FFFF can never trip
  assign neutral_computed_over = neutral_rms > neutral_warning_threshold;

  genvar ph;
  generate
    for (ph = 0; ph < 3; ph++) begin : g_phase
      assign volt_over[ph] = voltage_thd[ph] > voltage_distortion_threshold;
      assign curr_over[ph] = current_thd[ph] > current_distortion_threshold;
    end
  endgenerate

  assign voltage_distortion_over = |volt_over;
  assign current_distortion_over = |curr_over;

  // ----------------------------------------
  // Energy direction tracking
  // ----------------------------------------
  // Signs come from the accumulators, never from pulse outputs
  assign dir_sel = energy_fine_resolution ? energy_sign_fine : energy_sign_coarse;
  // A resolution switch only re-baselines, it does not flag
  assign dir_same_res = st_reg.dir_res_prev == energy_fine_resolution;

  genvar ch;
  generate
    for (ch = 0; ch <= `DIR_MSB; ch++) begin : g_dir
      assign dir_change[ch] = energy_update && st_reg.dir_primed && dir_same_res
        && (dir_sel[ch] != st_reg.dir_prev[ch]);
    end
  endgenerate

  // ----------------------------------------
  // Status set and read-clear terms
  // ----------------------------------------
  always_comb begin
    status_set = 16'h0000;
    status_set[`BIT_NEUTRAL_SECOND] = neutral_second_over;
    status_set[`BIT_NEUTRAL_COMPUTED] = neutral_computed_over;
    status_set[`BIT_VOLTAGE_DIST] = voltage_distortion_over;
    status_set[`BIT_CURRENT_DIST] = current_distortion_over;
    status_set[`DIR_MSB:0] = dir_change;
  end

  assign rd_status = reg_rd && (reg_addr == `ADDR_STATUS_SECOND);
  assign status_clr = rd_status ? st_reg.status_second : 16'h0000;

  // ----------------------------------------
  // Interrupt gating
  // ----------------------------------------
  // Set wins over a clear in the same cycle so no event is lost
  assign status_upd = ((st_reg.status_second & ~status_clr) | status_set) & `MASK_STATUS_SECOND;
  assign en_second_upd = (reg_wr && (reg_addr == `ADDR_EN_SECOND))
    ? (reg_wdata & `MASK_EN_SECOND) : st_reg.en_second;
  // Pin follows the values being registered, so it never lags its flags
  assign gated_second = status_upd & en_second_upd;
  assign gate_neutral = |gated_second[`BIT_NEUTRAL_SECOND:`BIT_NEUTRAL_COMPUTED];
  assign gate_dist = |gated_second[`BIT_VOLTAGE_DIST:`BIT_CURRENT_DIST];
  assign gate_dir = |gated_second[`DIR_MSB:0];

  // ----------------------------------------
  // Read data select
  // ----------------------------------------
  always_comb begin
    case (reg_addr)
      `ADDR_STATUS_SECOND: rd_mux = st_reg.status_second;
      `ADDR_EN_FIRST: rd_mux = st_reg.en_first;
      `ADDR_EN_SECOND: rd_mux = st_reg.en_second;
      `ADDR_ZX_SETUP: rd_mux = st_reg.zx_setup;
      default: rd_mux = 16'h0000;
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.status_second = status_upd;
    st_next.en_second = en_second_upd;
    if (reg_wr) begin
      case (reg_addr)
        `ADDR_EN_FIRST: st_next.en_first = reg_wdata & `MASK_EN_FIRST;
        `ADDR_ZX_SETUP: st_next.zx_setup = reg_wdata & `MASK_ZX_SETUP;
        default: st_next.zx_setup = st_reg.zx_setup;
      endcase
    end
    if (reg_rd) begin
      st_next.rdata = rd_mux;
    end
    if (energy_update) begin
      st_next.dir_prev = dir_sel;
      st_next.dir_res_prev = energy_fine_resolution;
      st_next.dir_primed = 1'b1;
    end
    st_next.irq_first = |(status_first_flags & st_next.en_first);
    st_next.irq_second = gate_neutral | gate_dist | gate_dir;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg.status_second <= `RST_STATUS_SECOND;
      st_reg.en_first <= `RST_EN_FIRST;
      st_reg.en_second <= `RST_EN_SECOND;
      st_reg.zx_setup <= `RST_ZX_SETUP;
      st_reg.dir_prev <= 8'h00;
      st_reg.dir_res_prev <= 1'b0;
      st_reg.dir_primed <= 1'b0;
      st_reg.rdata <= 16'h0000;
      st_reg.irq_first <= 1'b0;
      st_reg.irq_second <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata = st_reg.rdata;
  assign interrupt_pin_first = st_reg.irq_first;
  assign interrupt_pin_second = st_reg.irq_second;

  // ----------------------------------------
  // Zero-crossing outputs
  // ----------------------------------------
  genvar zx;
  generate
    for (zx = 0; zx < 3; zx++) begin : g_zx
      zero_cross_out u_zx (
        .core_clk(core_clk),
        .nrst(nrst),
        .wave_sign(wave_sign),
        .source(st_reg.zx_setup[`ZX_SRC_LSB0 + `ZX_SRC_STEP * zx +: 3]),
        .mode(st_reg.zx_setup[`ZX_MODE_LSB0 + `ZX_MODE_STEP * zx +: 2]),
        .outputs_off(st_reg.zx_setup[`BIT_ZX_OFF]),
        .zx_out(zx_out[zx])
      );
    end
  endgenerate

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence seq_status_read;
    rd_status;
  endsequence

  sequence seq_quiet_sources;
    (status_set == 16'h0000);
  endsequence

  sequence seq_en_first_write;
    reg_wr && (reg_addr == `ADDR_EN_FIRST);
  endsequence

  sequence seq_en_second_write;
    reg_wr && (reg_addr == `ADDR_EN_SECOND);
  endsequence

  sequence seq_zx_write;
    reg_wr && (reg_addr == `ADDR_ZX_SETUP);
  endsequence

  AST_NEUTRAL_FLAG: assert property (
    neutral_computed_over |=> st_reg.status_second[14])
    else $error("neutral overcurrent did not set bit 14");

  AST_NEUTRAL_UNSIGNED: assert property (
    (neutral_rms == 16'hFFFF && neutral_warning_threshold == 16'h0000)
      |=> st_reg.status_second[14])
    else $error("neutral compare is not unsigned");

  AST_VOLT_DIST_FLAG: assert property (
    (|volt_over) |=> st_reg.status_second[11])
    else $error("voltage distortion did not set bit 11");

  AST_CURR_DIST_FLAG: assert property (
    (|curr_over) |=> st_reg.status_second[10])
    else $error("current distortion did not set bit 10");

  AST_DIR_FLAG: assert property (
    (|dir_change) |=> ((st_reg.status_second[7:0] & $past(dir_change)) == $past(dir_change)))
    else $error("direction change not flagged");

  AST_RES_SWITCH: assert property (
    (energy_update && !dir_same_res)
      |=> ((st_reg.status_second[7:0] & ~$past(st_reg.status_second[7:0])) == 8'h00))
    else $error("resolution switch raised a direction flag");

  AST_IRQ_FIRST: assert property (
    ##1 (interrupt_pin_first == |($past(status_first_flags) & st_reg.en_first)))
    else $error("first interrupt pin does not follow enabled flags");

  AST_IRQ_SECOND: assert property (
    interrupt_pin_second == |(st_reg.status_second & st_reg.en_second))
    else $error("second interrupt pin does not follow enabled flags");

  AST_READ_DATA: assert property (
    seq_status_read |=> (reg_rdata == $past(st_reg.status_second)))
    else $error("status read returned wrong data");

  AST_READ_CLEAR: assert property (
    (seq_status_read and seq_quiet_sources) |=> (st_reg.status_second == 16'h0000) && !interrupt_pin_second)
    else $error("status read did not clear flags");

  AST_RESERVED_ZERO: assert property (
    ((st_reg.status_second & ~`MASK_STATUS_SECOND) == 16'h0000)
      && ((st_reg.en_first & ~`MASK_EN_FIRST) == 16'h0000)
      && ((st_reg.en_second & ~`MASK_EN_SECOND) == 16'h0000))
    else $error("reserved bit is set");

  AST_ZX_OFF: assert property (
    st_reg.zx_setup[0] |=> (zx_out == 3'h0))
    else $error("crossing outputs active while disabled");

  // ----------------------------------------
  // Gating and register checks
  // ----------------------------------------
  AST_NEUTRAL_SECOND_FLAG: assert property (
    neutral_second_over |=> st_reg.status_second[15])
    else $error("second neutral overcurrent did not set bit 15");

  AST_IRQ_NEUTRAL: assert property (
    (|(st_reg.status_second[15:14] & st_reg.en_second[15:14])) |-> interrupt_pin_second)
    else $error("enabled neutral flag did not raise second pin");

  AST_IRQ_DIST: assert property (
    (|(st_reg.status_second[11:10] & st_reg.en_second[11:10])) |-> interrupt_pin_second)
    else $error("enabled distortion flag did not raise second pin");

  AST_IRQ_DIR: assert property (
    (|(st_reg.status_second[7:0] & st_reg.en_second[7:0])) |-> interrupt_pin_second)
    else $error("enabled direction flag did not raise second pin");

  AST_NEUTRAL_LOW: assert property (
    (!neutral_computed_over && !st_reg.status_second[14]) |=> !st_reg.status_second[14])
    else $error("neutral flag set without overcurrent");

  AST_VOLT_DIST_LOW: assert property (
    (!voltage_distortion_over && !st_reg.status_second[11]) |=> !st_reg.status_second[11])
    else $error("voltage distortion flag set without excess");

  AST_CURR_DIST_LOW: assert property (
    (!current_distortion_over && !st_reg.status_second[10]) |=> !st_reg.status_second[10])
    else $error("current distortion flag set without excess");

  AST_DIR_QUIET: assert property (
    !energy_update |=> ((st_reg.status_second[7:0] & ~$past(st_reg.status_second[7:0])) == 8'h00))
    else $error("direction flag raised without an energy update");

  AST_EN_FIRST_WRITE: assert property (
    seq_en_first_write |=> (st_reg.en_first == ($past(reg_wdata) & `MASK_EN_FIRST)))
    else $error("first enable write did not land");

  AST_EN_SECOND_WRITE: assert property (
    seq_en_second_write |=> (st_reg.en_second == ($past(reg_wdata) & `MASK_EN_SECOND)))
    else $error("second enable write did not land");

  AST_ZX_WRITE: assert property (
    seq_zx_write |=> (st_reg.zx_setup == $past(reg_wdata)))
    else $error("crossing setup write did not land");

  AST_CFG_STABLE: assert property (
    !reg_wr |=> ($stable(st_reg.en_first) && $stable(st_reg.en_second) && $stable(st_reg.zx_setup)))
    else $error("configuration changed without a write");

  AST_RDATA_HOLD: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  AST_UNMAPPED_READ: assert property (
    (reg_rd && !(reg_addr inside {`ADDR_STATUS_SECOND, `ADDR_EN_FIRST, `ADDR_EN_SECOND, `ADDR_ZX_SETUP}))
      |=> (reg_rdata == 16'h0000))
    else $error("unmapped address read nonzero");

endmodule

// >>> logic/zero_cross_out.sv
`timescale 1ns/1ps
`include "meter_map.svh"

module zero_cross_out
  import meter_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [5:0] wave_sign,
  input wire logic [2:0] source,
  input wire logic [1:0] mode,
  input wire logic outputs_off,
  output logic zx_out
);

  zx_state_t st_reg;
  zx_state_t st_next;
  logic cur;
  logic prev;
  logic rise;
  logic fall;
  logic hit;

  // ----------------------------------------
  // Source select and edge detect
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    cur = 1'b0;
    prev = 1'b0;
    case (zx_source_t'(source))
      SRC_VOLT_A: begin cur = wave_sign[0]; prev = st_reg.sign_prev[0]; end
      SRC_VOLT_B: begin cur = wave_sign[1]; prev = st_reg.sign_prev[1]; end
      SRC_VOLT_C: begin cur = wave_sign[2]; prev = st_reg.sign_prev[2]; end
      SRC_CURR_A: begin cur = wave_sign[3]; prev = st_reg.sign_prev[3]; end
      SRC_CURR_B: begin cur = wave_sign[4]; prev = st_reg.sign_prev[4]; end
      SRC_CURR_C: begin cur = wave_sign[5]; prev = st_reg.sign_prev[5]; end
      default: begin cur = 1'b0; prev = 1'b0; end
    endcase
    rise = cur & ~prev;
    fall = ~cur & prev;
    case (zx_mode_t'(mode))
      MODE_RISING: hit = rise;
      MODE_FALLING: hit = fall;
      MODE_BOTH: hit = rise | fall;
      default: hit = 1'b0;
    endcase
    st_next.sign_prev = wave_sign;
    st_next.primed = 1'b1;
    // First sample after reset has no history to compare
    st_next.out = hit && st_reg.primed && !outputs_off;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign zx_out = st_reg.out;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  AST_ZX_FIXED_LOW: assert property (
    (source[1:0] == 2'h3) |=> !zx_out)
    else $error("fixed-low source produced a crossing");

  AST_ZX_NO_MODE: assert property (
    (mode == 2'h3) |=> !zx_out)
    else $error("no-crossing mode produced a crossing");

endmodule
